// >>> hw/fault_status_regs.vh
// constants for the printer fault and status ports block
`ifndef FAULT_STATUS_REGS_VH
`define FAULT_STATUS_REGS_VH
// column select bits on output_bus, active low
`define COL_ODD_BIT 0
`define COL_EVEN_BIT 1
`define COL_A_BIT 2
`define COL_B_BIT 3
`define COL_C_BIT 4
// fault port bit positions
`define FLT_PAPER_CLAMP 0
`define FLT_BAND_SPEED 1
`define FLT_TRANSDUCER 2
`define FLT_HAMMER_SUPPLY 3
`define FLT_CLAMP_VOLT 4
`define FLT_NEG_SUPPLY 5
`define FLT_TWELVE_VOLT 6
`define FLT_BAND_CURRENT 7
// status port bit positions
`define ST_EVEN_HAMMER 0
`define ST_BAND_IDENT 1
`define ST_ODD_HAMMER 2
`define ST_PRINT_INHIBIT 3
`define ST_IDENT_MASK 4
`define ST_IDENT_SAMPLE 5
`define ST_COLUMN 6
`define ST_HAMMER_TRIG 7
// timing
`define MCLK_HZ 40000000
`define CHAR_CLK_PULSE_US 100
`define CHAR_CLK_PULSE_CYC ((`CHAR_CLK_PULSE_US * (`MCLK_HZ / 1000000)))
`define TRIG_PER_CHAR 9
`define SELECT_MULT 54
`define FAULT_RESET 8'hFF
`endif

// >>> hw/printer_fault_status_ports.v
// timing, column select and fault/status ports of the printer status board
`include "fault_status_regs.vh"
module printer_fault_status_ports #(
   parameter MODEL_300 = 1,
   parameter integer SELECT_DIV = 25,
   parameter integer SERVO_TIMEOUT = 20000,
   parameter integer TRANSDUCER_TIMEOUT = 80000,
   parameter integer TRIG_DIV = 40
) (
   // clock and reset
   input wire mclk,
   input wire rst_b,
   // processor side decodes and buses
   input wire group_three_enable_b,
   input wire load_column_strobe_b,
   input wire clear_fault_strobe_b,
   input wire [7:0] output_bus,
   input wire port_zero_select_b,
   input wire port_one_select_b,
   output reg [7:0] input_bus_out,
   output reg [7:0] input_bus_oe_b,
   output reg system_change_line_b,
   // band timing
   input wire doubled_character_clock,
   input wire band_drive_servo_b,
   input wire band_ident_b,
   input wire ident_mask_b,
   input wire ident_sample_b,
   output reg character_clock,
   output reg hammer_pulse_reset_b,
   output reg hammer_trigger_b,
   output reg [4:0] column_select_b,
   output reg select_tick,
   // hammer and fault inputs, all asynchronous
   input wire odd_hammer_waveform_b,
   input wire even_hammer_waveform_b,
   input wire print_mode,
   input wire print_inhibit,
   input wire paper_clamp_fault_in_b,
   input wire band_overload_b,
   input wire [1:0] hammer_supply_cmp_b,
   input wire [1:0] twelve_volt_cmp_b,
   input wire negative_supply_cmp_b,
   input wire clamp_voltage_cmp_b,
   input wire unconditional_fault_b,
   output reg hammer_fire_flag_b,
   output reg hammer_supply_enable,
   output reg shutdown
);
   ////////////////////////////////////////////////////////////////////////////
   localparam integer NSYNC = 19;
   localparam integer PULSE_CYC = `CHAR_CLK_PULSE_CYC;
   reg [NSYNC-1:0] s1_q;
   reg [NSYNC-1:0] s2_q;
   // asynchronous pins pass two flops before use
   always @(posedge mclk) begin
      if (!rst_b) begin
         s1_q <= {NSYNC{1'b1}};
         s2_q <= {NSYNC{1'b1}};
      end else begin
         s1_q <= {doubled_character_clock, band_drive_servo_b, band_ident_b, ident_mask_b,
                  ident_sample_b, odd_hammer_waveform_b, even_hammer_waveform_b, print_mode,
                  print_inhibit, paper_clamp_fault_in_b, band_overload_b, hammer_supply_cmp_b,
                  twelve_volt_cmp_b, negative_supply_cmp_b, clamp_voltage_cmp_b,
                  unconditional_fault_b, 1'b1};
         s2_q <= s1_q;
      end
   end
   wire dcc = s2_q[18];
   wire servo_b = s2_q[17];
   wire ident_b = s2_q[16];
   wire imask_b = s2_q[15];
   wire isamp_b = s2_q[14];
   wire odd_wf_b = s2_q[13];
   wire even_wf_b = s2_q[12];
   wire pmode = s2_q[11];
   wire inhibit = s2_q[10];
   wire pcf_b = s2_q[9];
   wire bovl_b = s2_q[8];
   wire [1:0] hs_b = s2_q[7:6];
   wire [1:0] tv_b = s2_q[5:4];
   wire neg_b = s2_q[3];
   wire vcl_b = s2_q[2];
   wire uncond_b = s2_q[1];
   // spare bit 0 of the chain keeps the concatenation width fixed
   ////////////////////////////////////////////////////////////////////////////
   // character clock derivation
   reg dcc_q;
   reg chr_q;
   reg half_q;
   reg [12:0] pulse_q;
   wire dcc_rise = dcc & ~dcc_q;
   always @(posedge mclk) begin
      if (!rst_b) begin
         // matches the synchroniser's reset level, so no false edge after reset
         dcc_q <= 1'b1;
         half_q <= 1'b0;
         chr_q <= 1'b0;
         pulse_q <= 13'h0000;
      end else begin
         dcc_q <= dcc;
         if (MODEL_300 != 0) begin
            if (dcc_rise) begin
               half_q <= ~half_q;
               chr_q <= ~half_q;
            end
         end else if (dcc_rise) begin
            chr_q <= 1'b1;
            pulse_q <= PULSE_CYC[12:0];
         end else if (pulse_q != 13'h0000) begin
            pulse_q <= pulse_q - 13'h0001;
            if (pulse_q == 13'h0001)
               chr_q <= 1'b0;
         end
      end
   end
   reg chr_d1_q;
   wire chr_lead = chr_q & ~chr_d1_q;
   ////////////////////////////////////////////////////////////////////////////
   // column latch and select timing
   reg [4:0] col_q;
   reg [7:0] sel_cnt_q;
   reg sel_half_q;
   reg [5:0] sub_q;
   wire sel_pulse = (sel_cnt_q == SELECT_DIV - 1);
   always @(posedge mclk) begin
      if (!rst_b) begin
         col_q <= 5'h1F;
         chr_d1_q <= 1'b0;
         sel_cnt_q <= 8'h00;
         sel_half_q <= 1'b0;
         sub_q <= 6'h00;
         select_tick <= 1'b0;
      end else begin
         chr_d1_q <= chr_q;
         if (!group_three_enable_b && !load_column_strobe_b)
            col_q <= output_bus[4:0];
         select_tick <= 1'b0;
         if (chr_lead) begin
            sel_cnt_q <= 8'h00;
            sel_half_q <= 1'b0;
            sub_q <= 6'h00;
         end else if (sel_pulse) begin
            sel_cnt_q <= 8'h00;
            sel_half_q <= ~sel_half_q;
            if (sel_half_q) begin
               sub_q <= sub_q + 6'h01;
               select_tick <= 1'b1;
            end
         end else begin
            sel_cnt_q <= sel_cnt_q + 8'h01;
         end
      end
   end
   // one-hot check, bit 5 never looked at
   wire col_valid = (col_q == 5'h1E) | (col_q == 5'h1D) | (col_q == 5'h1B) |
                    (col_q == 5'h17) | (col_q == 5'h0F);
   ////////////////////////////////////////////////////////////////////////////
   // hammer trigger generator
   reg [7:0] trig_div_q;
   reg [3:0] trig_cnt_q;
   always @(posedge mclk) begin
      if (!rst_b) begin
         trig_div_q <= 8'h00;
         trig_cnt_q <= 4'h0;
         hammer_trigger_b <= 1'b1;
         hammer_pulse_reset_b <= 1'b1;
         column_select_b <= 5'h1F;
      end else begin
         column_select_b <= col_valid ? col_q : 5'h1F;
         hammer_pulse_reset_b <= ~(chr_lead & col_valid);
         hammer_trigger_b <= 1'b1;
         if (chr_lead && col_valid) begin
            trig_div_q <= 8'h00;
            trig_cnt_q <= 4'h0;
         end else if (trig_cnt_q < `TRIG_PER_CHAR) begin
            if (trig_div_q == TRIG_DIV - 1) begin
               trig_div_q <= 8'h00;
               trig_cnt_q <= trig_cnt_q + 4'h1;
               hammer_trigger_b <= 1'b0;
            end else begin
               trig_div_q <= trig_div_q + 8'h01;
            end
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // fault detection, register and ports
   reg servo_q;
   reg [15:0] servo_to_q;
   reg [16:0] trans_to_q;
   reg [7:0] fault_q;
   wire even_act = (MODEL_300 != 0) ? 1'b0 : ~even_wf_b;
   wire odd_act = ~odd_wf_b;
   wire [7:0] fault_now = {~bovl_b, ~tv_b[0] | ~tv_b[1], ~neg_b, ~vcl_b,
                           ~hs_b[0] | ~hs_b[1], trans_to_q == TRANSDUCER_TIMEOUT,
                           servo_to_q == SERVO_TIMEOUT, ~pcf_b};
   wire [7:0] status = {hammer_trigger_b, col_valid, isamp_b, imask_b, inhibit,
                        odd_act, ident_b, even_act};
   always @(posedge mclk) begin
      if (!rst_b) begin
         servo_q <= 1'b1;
         servo_to_q <= 16'h0000;
         trans_to_q <= 17'h00000;
         fault_q <= 8'h00;
         input_bus_out <= 8'hFF;
         input_bus_oe_b <= 8'hFF;
         system_change_line_b <= 1'b1;
         hammer_fire_flag_b <= 1'b1;
         hammer_supply_enable <= 1'b0;
         shutdown <= 1'b0;
      end else begin
         servo_q <= servo_b;
         if (servo_b != servo_q)
            servo_to_q <= 16'h0000;
         else if (servo_to_q != SERVO_TIMEOUT)
            servo_to_q <= servo_to_q + 16'h0001;
         if (dcc_rise)
            trans_to_q <= 17'h00000;
         else if (trans_to_q != TRANSDUCER_TIMEOUT)
            trans_to_q <= trans_to_q + 17'h00001;
         // new fault wins over a clear in the same cycle
         if (!group_three_enable_b && !clear_fault_strobe_b)
            fault_q <= fault_now;
         else
            fault_q <= fault_q | fault_now;
         system_change_line_b <= ~((|fault_q) | inhibit);
         hammer_fire_flag_b <= ~((odd_act | even_act) & ~pmode);
         // supply stays off until the processor clears the latched fire
         if ((odd_act | even_act) & ~pmode)
            hammer_supply_enable <= 1'b0;
         else if (!group_three_enable_b && !clear_fault_strobe_b)
            hammer_supply_enable <= 1'b1;
         shutdown <= ~uncond_b;
         if (port_zero_select_b && !port_one_select_b) begin
            input_bus_out <= ~fault_q;
            input_bus_oe_b <= 8'h00;
         end else if (!port_zero_select_b && port_one_select_b) begin
            input_bus_out <= status;
            input_bus_oe_b <= 8'h00;
         end else begin
            input_bus_out <= 8'hFF;
            input_bus_oe_b <= 8'hFF;
         end
      end
   end
   always @(posedge mclk) begin
      if (!rst_b)
         character_clock <= 1'b0;
      else
         character_clock <= chr_q;
   end
endmodule // printer_fault_status_ports

// >>> testbench/fault_ports_chk_sva.sv
// assertions on the printer fault and status ports
module fault_ports_chk #(parameter MODEL_300 = 1) (
   // clock and reset
   input wire mclk,
   input wire rst_b,
   // processor side
   input wire group_three_enable_b,
   input wire load_column_strobe_b,
   input wire [7:0] output_bus,
   input wire port_zero_select_b,
   input wire port_one_select_b,
   input wire [7:0] input_bus_out,
   input wire [7:0] input_bus_oe_b,
   input wire system_change_line_b,
   // timing, hammers, shutdown
   input wire hammer_pulse_reset_b,
   input wire hammer_trigger_b,
   input wire [4:0] column_select_b,
   input wire print_mode,
   input wire odd_hammer_waveform_b,
   input wire unconditional_fault_b,
   input wire hammer_supply_enable,
   input wire shutdown
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   wire ld_take = !group_three_enable_b && !load_column_strobe_b;
   ////////////////////////////////////////////////////////////////////////////////
   bus_release_a: assert property (port_zero_select_b == port_one_select_b |=> &input_bus_oe_b)
      else $error("bus not released");
   fault_port_a: assert property (port_zero_select_b && !port_one_select_b |=> input_bus_oe_b == 8'h00)
      else $error("fault port not driven");
   status_port_a: assert property (!port_zero_select_b && port_one_select_b |=>
      input_bus_oe_b == 8'h00 && (MODEL_300 == 0 || !input_bus_out[0])) else $error("status port wrong");
   column_load_a: assert property (ld_take && $onehot(~output_bus[4:0]) |-> ##2
      column_select_b == $past(output_bus[4:0], 2)) else $error("column not loaded");
   column_refuse_a: assert property (ld_take && !$onehot(~output_bus[4:0]) |->
      ##2 column_select_b == 5'h1F) else $error("bad column accepted");
   // reset waits for the next character clock lead, up to 48 cycles later
   pulse_reset_a: assert property (ld_take && $onehot(~output_bus[4:0]) |->
      ##[1:48] !hammer_pulse_reset_b) else $error("no hammer reset");
   trig_pulse_a: assert property ($fell(hammer_trigger_b) |=> hammer_trigger_b)
      else $error("trigger too long");
   fault_change_a: assert property (port_zero_select_b && !port_one_select_b ##1 input_bus_out != 8'hFF
      |-> !system_change_line_b || !$past(system_change_line_b)) else $error("change line idle");
   misfire_off_a: assert property ((!print_mode && !odd_hammer_waveform_b) [*4] |-> ##[0:6] !hammer_supply_enable)
      else $error("supply kept on");
   shut_down_a: assert property (!unconditional_fault_b [*3] |-> ##[0:4] shutdown)
      else $error("no shutdown");
   cover property (ld_take ##1 !hammer_pulse_reset_b);
   cover property (!system_change_line_b);
   cover property (shutdown);
endmodule // fault_ports_chk
////////////////////////////////////////////////////////////////////////////////
bind printer_fault_status_ports fault_ports_chk #(.MODEL_300(MODEL_300)) sva (.*);

// >>> testbench/proc_board_model.sv
// processor board model: control decodes and fault/status port reads
module proc_board_model (
   // clock
   input wire mclk,
   // decodes and buses
   output logic group_three_enable_b = 1'b1,
   output logic load_column_strobe_b = 1'b1,
   output logic clear_fault_strobe_b = 1'b1,
   output logic [7:0] output_bus = 8'hFF,
   output logic port_zero_select_b = 1'b1,
   output logic port_one_select_b = 1'b1,
   input wire [7:0] input_bus_out,
   input wire [7:0] input_bus_oe_b
);
   // exactly one strobe per enabled decode; bus flips when released
   task automatic strobe(input logic clr, input logic [7:0] v);
      @(posedge mclk);
      group_three_enable_b <= 1'b0;
      load_column_strobe_b <= clr;
      clear_fault_strobe_b <= ~clr;
      output_bus <= v;
      @(posedge mclk);
      group_three_enable_b <= 1'b1;
      load_column_strobe_b <= 1'b1;
      clear_fault_strobe_b <= 1'b1;
      output_bus <= ~v;
   endtask
   // input bus has pull-ups, so released bits read high
   task automatic rd(input logic [1:0] sel, output logic [7:0] d, output logic [7:0] oe);
      @(posedge mclk);
      {port_zero_select_b, port_one_select_b} <= sel;
      @(posedge mclk);
      @(negedge mclk);
      oe = input_bus_oe_b;
      d = input_bus_out | input_bus_oe_b;
      @(posedge mclk);
      {port_zero_select_b, port_one_select_b} <= 2'b11;
   endtask
endmodule // proc_board_model

// >>> testbench/test_printer_fault_status_ports.sv
// self-checking bench for the fault and status ports
module test_printer_fault_status_ports;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0, rst_b = 1'b0, doubled_character_clock = 1'b0, band_drive_servo_b = 1'b1;
   logic odd_hammer_waveform_b = 1'b1, print_mode = 1'b1, print_inhibit = 1'b0;
   logic unconditional_fault_b = 1'b1, band_ident_b = 1'b1, ident_mask_b = 1'b1;
   logic ident_sample_b = 1'b1, even_hammer_waveform_b = 1'b1, run = 1'b1;
   logic [7:0] flt = 8'h00, d, oe;
   wire paper_clamp_fault_in_b = ~flt[0];
   wire band_overload_b = ~flt[7];
   wire [1:0] hammer_supply_cmp_b = {~flt[3], 1'b1};
   wire [1:0] twelve_volt_cmp_b = {1'b1, ~flt[6]};
   wire negative_supply_cmp_b = ~flt[5];
   wire clamp_voltage_cmp_b = ~flt[4];
   wire group_three_enable_b, load_column_strobe_b, clear_fault_strobe_b;
   wire port_zero_select_b, port_one_select_b, system_change_line_b, character_clock;
   wire hammer_pulse_reset_b, hammer_trigger_b, select_tick, hammer_fire_flag_b;
   wire hammer_supply_enable, shutdown;
   wire [7:0] output_bus, input_bus_out, input_bus_oe_b;
   wire [4:0] column_select_b;
   int err_total = 0, n_checks = 0, k = 0;
   // output_bus value beside the column it selects
   logic [15:0] rows [7] = '{16'h3E1E, 16'hFD1D, 16'h3B1B, 16'h1717, 16'h2F0F, 16'h3C1F, 16'h1E1E};
   logic [7:0] fbits [6] = '{8'h01, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
   printer_fault_status_ports #(.SELECT_DIV(3), .SERVO_TIMEOUT(20), .TRANSDUCER_TIMEOUT(40),
      .TRIG_DIV(4)) uut (.*);
   proc_board_model m (.*);
   initial forever #12.5 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////////////////////
   // band clocks stand still when run is low
   always @(posedge mclk) begin
      k <= (k == 4) ? 0 : k + 1;
      if (run && k == 4) begin
         doubled_character_clock <= ~doubled_character_clock;
         band_drive_servo_b <= ~band_drive_servo_b;
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge mclk);
      err_total++;
      complete_run;
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      @(negedge mclk);
      chk({3'h7, column_select_b} & input_bus_oe_b, 8'hFF);
      foreach (rows[i]) begin
         m.strobe(1'b0, rows[i][15:8]);
         @(posedge mclk);
         @(negedge mclk);
         chk({3'h0, column_select_b}, rows[i][7:0]);
      end
      // clear anything latched while the band came up
      m.strobe(1'b1, 8'h00);
      m.rd(2'b10, d, oe);
      chk(d, 8'hFF);
      foreach (fbits[i]) begin
         @(posedge mclk);
         flt <= fbits[i];
         repeat (6) @(posedge mclk);
         flt <= 8'h00;
         m.rd(2'b10, d, oe);
         chk(d, ~fbits[i]);
         chk({7'h0, system_change_line_b}, 8'h00);
         m.strobe(1'b1, 8'h00);
         repeat (4) @(posedge mclk);
         m.rd(2'b10, d, oe);
         chk({d[7:1], system_change_line_b}, 8'hFF);
      end
      run <= 1'b0;
      repeat (60) @(posedge mclk);
      m.rd(2'b10, d, oe);
      chk(d, 8'hF9);
      run <= 1'b1;
      print_inhibit <= 1'b1;
      odd_hammer_waveform_b <= 1'b0;
      repeat (40) @(posedge mclk);
      m.strobe(1'b1, 8'h00);
      repeat (4) @(posedge mclk);
      m.rd(2'b01, d, oe);
      chk(d & 8'h0D, 8'h0C);
      chk({oe[7:1], system_change_line_b}, 8'h00);
      m.rd(2'b11, d, oe);
      chk(oe, 8'hFF);
      m.rd(2'b00, d, oe);
      chk(oe, 8'hFF);
      print_inhibit <= 1'b0;
      print_mode <= 1'b0;
      repeat (10) @(posedge mclk);
      @(negedge mclk);
      chk({7'h0, hammer_fire_flag_b}, 8'h00);
      @(posedge mclk);
      odd_hammer_waveform_b <= 1'b1;
      unconditional_fault_b <= 1'b0;
      repeat (8) @(posedge mclk);
      @(negedge mclk);
      chk({6'h0, shutdown, hammer_supply_enable}, 8'h02);
      @(posedge mclk);
      unconditional_fault_b <= 1'b1;
      rst_b <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      @(negedge mclk);
      chk({shutdown, 2'h0, column_select_b}, 8'h1F);
      complete_run;
   end
endmodule // test_printer_fault_status_ports
